// >>> design/ldc_dim_front.sv
`timescale 1ns/1ps
`default_nettype none

// synchroniser and low-time measure for the single-wire input
module ldc_dim_front #(
  parameter int LO_MAX_CYC = 25000
) (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic                      pin_in,
  output logic                           rise_ok,
  output logic                           too_long,
  output logic [ldc_pkg::CNT_W-1:0]      low_cnt
);

  // counter saturates above every threshold so a long low never wraps
  localparam logic [ldc_pkg::CNT_W-1:0] CAP = {ldc_pkg::CNT_W{1'b1}};

  logic                      s1_ff, s2_ff, s3_ff;
  logic [ldc_pkg::CNT_W-1:0] low_ff, nxt_low;
  logic                      rise_ff, nxt_rise;
  logic                      long_ff, nxt_long;

  always_comb begin
    nxt_low  = low_ff;
    if (s2_ff) begin
      nxt_low = '0;
    end else if (low_ff != CAP) begin
      nxt_low = low_ff + ldc_pkg::CNT_W'(1);
    end
    // short lows are glitches: their rising edge is dropped
    nxt_rise = s2_ff & ~s3_ff & (low_ff >= ldc_pkg::CNT_W'(ldc_pkg::LO_MIN_CYC));
    nxt_long = ~s2_ff & (low_ff >= ldc_pkg::CNT_W'(LO_MAX_CYC));
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_ff   <= 1'b0;
      s2_ff   <= 1'b0;
      s3_ff   <= 1'b0;
      low_ff  <= CAP;
      rise_ff <= 1'b0;
      long_ff <= 1'b1;
    end else begin
      s1_ff   <= pin_in;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      low_ff  <= nxt_low;
      rise_ff <= nxt_rise;
      long_ff <= nxt_long;
    end
  end

  assign rise_ok  = rise_ff;
  assign too_long = long_ff;
  assign low_cnt  = low_ff;

endmodule

`default_nettype wire

// >>> design/ldc_led_dimming_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - input low for 1.5 ms or more gives zero-current shutdown
// - a gain change is given about 40 us to settle
// - first rise from shutdown enables at full-scale gain 132
// - each later rise halves the gain down to 4.125
// - seventh rise returns to 132, sequence keeps cycling
// - lows shorter than 0.2 us are ignored, no gain change
// - lows longer than 100 us are taken as shutdown
// - supply lockout disables all channels and shuts down
// - in shutdown all three sinks are high impedance
// - in shutdown the set-resistor pin is high impedance
// - pump starts in 1x and stays while currents regulate
// - lost regulation steps pump up one mode per 400 us
// - enough supply for 1x jumps straight back to 1x
// - open channels are left out of regulation decisions
// - all channels open forces 1x
// - output overvoltage resets pump to 1x and restarts evaluation
// - over-temperature shuts down until the cooled indication returns
module ldc_led_dimming_ctrl #(
  parameter int LO_MAX_CYC = ldc_pkg::LO_MAX_CYC,
  parameter int PWRDWN_CYC = ldc_pkg::PWRDWN_CYC,
  parameter int SETTLE_CYC = ldc_pkg::SETTLE_CYC,
  parameter int STEP_CYC   = ldc_pkg::STEP_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic                        enable_dimming_input,
  input  wire logic                        supply_lockout,
  input  wire logic                        pump_output_overvoltage,
  input  wire logic                        die_over_temp,
  input  wire logic                        die_cooled,
  input  wire logic                        supply_input_enough_1x,
  input  wire logic [2:0]                  led_regulated,
  input  wire logic [2:0]                  led_open,
  output logic                             led_sink_first_oe_n,
  output logic                             led_sink_second_oe_n,
  output logic                             led_sink_third_oe_n,
  output logic                             current_set_resistor_pin_oe_n,
  output logic                             device_enabled,
  output logic [ldc_pkg::GAIN_W-1:0]       gain_index,
  output logic [ldc_pkg::GAINV_W-1:0]      gain_eighths,
  output logic                             current_settled,
  output logic [3:0]                       pump_mode
);

  ////////////////////////////////////////////////////////////////////////////////
  // input front end and timers
  logic                      rise_ok;
  logic                      too_long;
  logic [ldc_pkg::CNT_W-1:0] low_cnt;
  logic                      settle_done;
  logic                      step_done;
  logic                      step_run;
  logic                      settle_run;
  logic                      settling_ff, nxt_settling;

  ldc_dim_front #(
    .LO_MAX_CYC (LO_MAX_CYC)
  ) u_front (
    .clk      (clk),
    .srst     (srst),
    .pin_in   (enable_dimming_input),
    .rise_ok  (rise_ok),
    .too_long (too_long),
    .low_cnt  (low_cnt)
  );

  ldc_timer #(
    .LIMIT (SETTLE_CYC)
  ) u_settle (
    .clk  (clk),
    .srst (srst),
    .run  (settle_run),
    .done (settle_done)
  );

  ldc_timer #(
    .LIMIT (STEP_CYC)
  ) u_step (
    .clk  (clk),
    .srst (srst),
    .run  (step_run),
    .done (step_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // enable and gain sequencing
  ldc_pkg::ldc_state_t        state_ff, nxt_state;
  logic [ldc_pkg::GAIN_W-1:0] gain_ff, nxt_gain;
  logic                       gain_step;

  always_comb begin
    nxt_state = state_ff;
    nxt_gain  = gain_ff;
    gain_step = 1'b0;
    case (state_ff)
      ldc_pkg::LDC_OFF: begin
        nxt_gain = ldc_pkg::GAIN_FULL;
        if (!supply_lockout && rise_ok) begin
          nxt_state = ldc_pkg::LDC_ON;
          gain_step = 1'b1;
        end
      end
      ldc_pkg::LDC_ON: begin
        if (supply_lockout || too_long) begin
          nxt_state = ldc_pkg::LDC_OFF;
        end else if (die_over_temp) begin
          nxt_state = ldc_pkg::LDC_HOT;
        end else if (rise_ok) begin
          gain_step = 1'b1;
          nxt_gain  = (gain_ff == ldc_pkg::GAIN_LAST) ? ldc_pkg::GAIN_FULL
                    : gain_ff + ldc_pkg::GAIN_W'(1);
        end
      end
      ldc_pkg::LDC_HOT: begin
        // the gain chosen before overheating is kept for the resume
        if (supply_lockout || too_long) begin
          nxt_state = ldc_pkg::LDC_OFF;
        end else if (die_cooled && !die_over_temp) begin
          nxt_state = ldc_pkg::LDC_ON;
        end
      end
      default: begin
        nxt_state = ldc_pkg::LDC_OFF;
        nxt_gain  = ldc_pkg::GAIN_FULL;
      end
    endcase
    // a new step wins over the timer finishing the previous one
    nxt_settling = gain_step | (settling_ff & ~settle_done);
    // a step while settling restarts the interval, so settled counts from the last step
    settle_run   = settling_ff & ~gain_step;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff    <= ldc_pkg::LDC_OFF;
      gain_ff     <= ldc_pkg::GAIN_FULL;
      settling_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      gain_ff     <= nxt_gain;
      settling_ff <= nxt_settling;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // charge-pump mode selection
  ldc_pkg::ldc_pump_t pump_ff, nxt_pump;
  logic               reg_lost;
  logic               all_open;
  logic               pump_hold_1x;

  always_comb begin
    reg_lost     = |(~led_regulated & ~led_open);
    all_open     = &led_open;
    pump_hold_1x = (state_ff != ldc_pkg::LDC_ON) | pump_output_overvoltage | all_open
                 | supply_input_enough_1x;
    step_run     = ~pump_hold_1x & reg_lost & (pump_ff != ldc_pkg::LDC_PM_2X);
    nxt_pump     = pump_ff;
    if (pump_hold_1x) begin
      nxt_pump = ldc_pkg::LDC_PM_1X;
    end else if (step_done) begin
      case (pump_ff)
        ldc_pkg::LDC_PM_1X:  nxt_pump = ldc_pkg::LDC_PM_133;
        ldc_pkg::LDC_PM_133: nxt_pump = ldc_pkg::LDC_PM_15;
        ldc_pkg::LDC_PM_15:  nxt_pump = ldc_pkg::LDC_PM_2X;
        ldc_pkg::LDC_PM_2X:  nxt_pump = ldc_pkg::LDC_PM_2X;
        default:             nxt_pump = ldc_pkg::LDC_PM_1X;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pump_ff <= ldc_pkg::LDC_PM_1X;
    end else begin
      pump_ff <= nxt_pump;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registered pin controls; sinks and set pin float unless running
  logic [2:0]                  sink_oe_n_ff, nxt_sink_oe_n;
  logic                        current_set_resistor_pin_oe_n_ff, nxt_current_set_resistor_pin_oe_n;
  logic                        enabled_ff, nxt_enabled;
  logic [ldc_pkg::GAINV_W-1:0] gainv_ff, nxt_gainv;
  logic                        settled_ff, nxt_settled;

  always_comb begin
    nxt_enabled   = (nxt_state == ldc_pkg::LDC_ON);
    nxt_sink_oe_n = nxt_enabled ? 3'h0 : ldc_pkg::SINK_RST;
    nxt_current_set_resistor_pin_oe_n = ~nxt_enabled;
    nxt_gainv     = ldc_pkg::GAIN_TABLE[nxt_gain];
    nxt_settled   = nxt_enabled & ~nxt_settling;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sink_oe_n_ff <= ldc_pkg::SINK_RST;
      current_set_resistor_pin_oe_n_ff <= 1'b1;
      enabled_ff   <= 1'b0;
      gainv_ff     <= ldc_pkg::GAIN_TABLE[0];
      settled_ff   <= 1'b0;
    end else begin
      sink_oe_n_ff <= nxt_sink_oe_n;
      current_set_resistor_pin_oe_n_ff <= nxt_current_set_resistor_pin_oe_n;
      enabled_ff   <= nxt_enabled;
      gainv_ff     <= nxt_gainv;
      settled_ff   <= nxt_settled;
    end
  end

  assign led_sink_first_oe_n           = sink_oe_n_ff[0];
  assign led_sink_second_oe_n          = sink_oe_n_ff[1];
  assign led_sink_third_oe_n           = sink_oe_n_ff[2];
  assign current_set_resistor_pin_oe_n = current_set_resistor_pin_oe_n_ff;
  assign device_enabled                = enabled_ff;
  assign gain_index                    = gain_ff;
  assign gain_eighths                  = gainv_ff;
  assign current_settled               = settled_ff;
  assign pump_mode                     = pump_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // checks; the run-length counter below is read by the assertions only
  logic [ldc_pkg::CNT_W-1:0] run_len_ff, nxt_run_len;

  // cycles the step timer has run since the last mode change, saturating
  always_comb begin
    nxt_run_len = run_len_ff;
    if (!step_run || nxt_pump != pump_ff) begin
      nxt_run_len = '0;
    end else if (run_len_ff != {ldc_pkg::CNT_W{1'b1}}) begin
      nxt_run_len = run_len_ff + ldc_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      run_len_ff <= '0;
    end else begin
      run_len_ff <= nxt_run_len;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // the sample where the level is back high still carries the old count
  power_down_a: assert property (
    low_cnt >= ldc_pkg::CNT_W'(PWRDWN_CYC) && !u_front.s2_ff |-> ##2 !device_enabled)
    else $error("long low did not shut down");
  first_rise_a: assert property (
    state_ff == ldc_pkg::LDC_OFF && rise_ok && !supply_lockout
    |=> gain_ff == ldc_pkg::GAIN_FULL && device_enabled && gain_eighths == 11'h420)
    else $error("enable did not select full gain");
  halve_gain_a: assert property (
    state_ff == ldc_pkg::LDC_ON && rise_ok && !supply_lockout && !too_long && !die_over_temp
    && gain_ff != ldc_pkg::GAIN_LAST |=> gain_eighths == ($past(gain_eighths) >> 1))
    else $error("gain did not halve");
  wrap_gain_a: assert property (
    state_ff == ldc_pkg::LDC_ON && rise_ok && !supply_lockout && !too_long && !die_over_temp
    && gain_ff == ldc_pkg::GAIN_LAST |=> gain_ff == ldc_pkg::GAIN_FULL)
    else $error("gain did not wrap to full");
  settle_time_a: assert property (
    $rose(settling_ff) |-> settling_ff [*8] ##0 !current_settled)
    else $error("settling ended too early");
  glitch_drop_a: assert property (
    $rose(u_front.s2_ff) && low_cnt < ldc_pkg::CNT_W'(ldc_pkg::LO_MIN_CYC) |=> !rise_ok)
    else $error("short low was counted");
  lockout_off_a: assert property (
    supply_lockout |-> ##2 !device_enabled && led_sink_first_oe_n && led_sink_third_oe_n)
    else $error("lockout did not shut down");
  float_pins_a: assert property (
    !device_enabled |-> led_sink_first_oe_n && led_sink_second_oe_n && led_sink_third_oe_n
    && current_set_resistor_pin_oe_n)
    else $error("pins driven in shutdown");
  // steps come one timer period apart, the count restarting at zero after each
  step_up_a: assert property (
    $changed(pump_mode) && pump_mode != ldc_pkg::LDC_PM_1X
    |-> $past(run_len_ff) >= ldc_pkg::CNT_W'(STEP_CYC - 1))
    else $error("pump stepped before delay");
  back_1x_a: assert property (
    supply_input_enough_1x |=> pump_mode == ldc_pkg::LDC_PM_1X)
    else $error("pump did not return to 1x");
  all_open_a: assert property (
    led_open == 3'h7 |=> pump_mode == ldc_pkg::LDC_PM_1X)
    else $error("all open did not force 1x");
  ovp_reset_a: assert property (
    pump_output_overvoltage |=> pump_mode == ldc_pkg::LDC_PM_1X ##1 !step_done)
    else $error("overvoltage did not reset pump");
  hot_off_a: assert property (
    state_ff == ldc_pkg::LDC_ON && die_over_temp && !supply_lockout && !too_long
    |=> state_ff == ldc_pkg::LDC_HOT ##0 !device_enabled)
    else $error("over temperature did not shut down");

  // protection, pin release, settling, gain and state encoding, sync and pump ordering
  hot_gain_a: assert property (
    state_ff == ldc_pkg::LDC_HOT |=> gain_ff == $past(gain_ff))
    else $error("gain moved during thermal shutdown");
  hot_stay_a: assert property (
    state_ff == ldc_pkg::LDC_HOT && !die_cooled && !supply_lockout && !too_long
    |=> state_ff == ldc_pkg::LDC_HOT)
    else $error("left thermal shutdown while hot");
  long_low_a: assert property (
    too_long && state_ff != ldc_pkg::LDC_OFF |=> !device_enabled)
    else $error("long low left device running");
  lockout_block_a: assert property (
    state_ff == ldc_pkg::LDC_OFF && supply_lockout |=> !device_enabled)
    else $error("enabled during lockout");
  current_set_resistor_pin_float_a: assert property (
    current_set_resistor_pin_oe_n == !device_enabled)
    else $error("set pin does not follow enable");
  settle_flag_a: assert property (
    gain_step |=> !current_settled)
    else $error("settled flag high right after a step");
  gain_range_a: assert property (
    gain_index <= ldc_pkg::GAIN_LAST)
    else $error("gain index past last level");
  pump_legal_a: assert property (
    $onehot(pump_mode))
    else $error("pump mode not one-hot");
  state_legal_a: assert property (
    $onehot(state_ff))
    else $error("state not one-hot");
  step_order_a: assert property (
    $changed(pump_mode) && pump_mode != ldc_pkg::LDC_PM_1X
    |-> pump_mode == ($past(pump_mode) << 1))
    else $error("pump skipped or stepped down");
  open_skip_a: assert property (
    (~led_regulated & ~led_open) == 3'h0 |-> !step_run)
    else $error("open channel drove a pump step");
  sync_delay_a: assert property (
    $rose(enable_dimming_input) |-> ##2 u_front.s2_ff)
    else $error("input level not synchronised in two cycles");

  wrap_seen_c: cover property (state_ff == ldc_pkg::LDC_ON && gain_ff == ldc_pkg::GAIN_LAST
    && rise_ok);
  pump_2x_c:   cover property (pump_mode == ldc_pkg::LDC_PM_2X);
  hot_back_c:  cover property (state_ff == ldc_pkg::LDC_HOT ##1 state_ff == ldc_pkg::LDC_ON);
  timeout_c:   cover property (device_enabled ##1 too_long ##2 !device_enabled);
  glitch_c:    cover property ($rose(u_front.s2_ff)
    && low_cnt < ldc_pkg::CNT_W'(ldc_pkg::LO_MIN_CYC));

endmodule

`default_nettype wire

// >>> design/ldc_pkg.sv
package ldc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // clock and interval figures, clock period in ps, other times in ns
  localparam int CLK_PERIOD_PS = 4000;
  localparam int LO_MIN_NS     = 200;
  localparam int LO_MAX_NS     = 100000;
  localparam int PWRDWN_NS     = 1500000;
  localparam int SETTLE_NS     = 40000;
  localparam int STEP_NS       = 400000;

  // least times round up, longest and typical times round down
  localparam int LO_MIN_CYC = (LO_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LO_MAX_CYC = (LO_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int PWRDWN_CYC = (PWRDWN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETTLE_CYC = (SETTLE_NS * 1000) / CLK_PERIOD_PS;
  localparam int STEP_CYC   = (STEP_NS * 1000) / CLK_PERIOD_PS;

  localparam int CNT_W = 20;

  ////////////////////////////////////////////////////////////////////////////////
  // gain sequence, gain held in eighths so 4.125 stays exact
  localparam int             GAIN_W     = 3;
  localparam logic [2:0]     GAIN_FULL  = 3'h0;
  localparam logic [2:0]     GAIN_LAST  = 3'h5;
  localparam int             GAINV_W    = 11;
  localparam logic [0:5][10:0] GAIN_TABLE = {11'h420, 11'h210, 11'h108,
                                             11'h084, 11'h042, 11'h021};
  localparam logic [2:0]     SINK_RST   = 3'h7;

  typedef enum logic [2:0] {
    LDC_OFF = 3'b001,
    LDC_ON  = 3'b010,
    LDC_HOT = 3'b100
  } ldc_state_t;

  typedef enum logic [3:0] {
    LDC_PM_1X  = 4'b0001,
    LDC_PM_133 = 4'b0010,
    LDC_PM_15  = 4'b0100,
    LDC_PM_2X  = 4'b1000
  } ldc_pump_t;

endpackage

// >>> design/ldc_timer.sv
`timescale 1ns/1ps
`default_nettype none

// interval counter, cleared while run is low: pulses done every LIMIT cycles of run
module ldc_timer #(
  parameter int LIMIT = 16
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic run,
  output logic      done
);

  logic [ldc_pkg::CNT_W-1:0] cnt_ff;
  logic [ldc_pkg::CNT_W-1:0] nxt_cnt;
  logic                      done_ff;
  logic                      nxt_done;

  always_comb begin
    nxt_cnt  = '0;
    nxt_done = 1'b0;
    if (run) begin
      if (cnt_ff == ldc_pkg::CNT_W'(LIMIT - 1)) begin
        nxt_done = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + ldc_pkg::CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;

endmodule

`default_nettype wire

// >>> testbench/ldc_host_pin.sv
`timescale 1ns/1ps
`default_nettype none

// host general purpose output that drives the single-wire pin
module ldc_host_pin #(
  parameter int SETUP_CYC = 2500,
  parameter int LO_MIN    = 50
) (
  input  wire logic clk,
  output var logic  pin
);
  initial pin = 1'b0;

  // called at a falling edge; the pin is always driven, never left floating
  task automatic hold(input logic lvl, input int n);
    pin = lvl;
    repeat (n) @(negedge clk);
  endtask

  // high for the whole setup time after shutdown, before any pulse
  task automatic wake();
    hold(1'b1, SETUP_CYC);
  endtask

  // one dimming pulse; a low under LO_MIN is only sent when a glitch is wanted
  task automatic pulse(input int lo, input int hi);
    hold(1'b0, lo);
    hold(1'b1, (hi < LO_MIN) ? LO_MIN : hi);
  endtask
endmodule

`default_nettype wire

// >>> testbench/test_led_pulse_dimming_controller.sv
`timescale 1ns/1ps
`default_nettype none

module test_led_pulse_dimming_controller;
  // shortened counts keep the run small; expectations derive from these
  localparam int STEP   = 20;
  localparam int SETTLE = 20;
  localparam int LO_MAX = 200;
  localparam int LIMIT  = 20000;

  logic        clk, srst, lockout, ovp, hot, cooled, enough, pin;
  logic        s1_n, s2_n, s3_n, current_set_resistor_pin_n, en, settled;
  logic [2:0]  reg_ok, open, gidx;
  logic [10:0] geighths;
  logic [3:0]  pmode;
  int          n_errors  = 0;
  int          cmp_count = 0;
  int          cycles    = 0;

  ldc_host_pin host (.clk(clk), .pin(pin));

  ldc_led_dimming_ctrl #(
    .LO_MAX_CYC(LO_MAX), .PWRDWN_CYC(LO_MAX + 5), .SETTLE_CYC(SETTLE), .STEP_CYC(STEP)
  ) dut (
    .clk(clk), .srst(srst), .enable_dimming_input(pin), .supply_lockout(lockout),
    .pump_output_overvoltage(ovp), .die_over_temp(hot), .die_cooled(cooled),
    .supply_input_enough_1x(enough), .led_regulated(reg_ok), .led_open(open),
    .led_sink_first_oe_n(s1_n), .led_sink_second_oe_n(s2_n), .led_sink_third_oe_n(s3_n),
    .current_set_resistor_pin_oe_n(current_set_resistor_pin_n), .device_enabled(en), .gain_index(gidx),
    .gain_eighths(geighths), .current_settled(settled), .pump_mode(pmode)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles >= LIMIT) begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk_on(input logic on);
    chk("device_enabled", 11'(on), 11'(en));
    chk("sink_oe_n", 11'({3{~on}}), 11'({s3_n, s2_n, s1_n}));
    chk("current_set_resistor_pin_oe_n", {10'h000, ~on}, 11'(current_set_resistor_pin_n));
  endtask

  // gain is held in eighths: 132 x 8 halved per step
  task automatic chk_gain(input int idx);
    chk("gain_index", 11'(idx), 11'(gidx));
    chk("gain_eighths", 11'h420 >> idx, geighths);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk_on(1'b0);
    chk_gain(0);
    chk("settled", 11'h000, 11'(settled));
    chk("pump_mode", 11'h001, 11'(pmode));
    $display("t_reset done");
  endtask

  task automatic t_enable();
    host.wake();
    chk_on(1'b1);
    chk_gain(0);
    host.hold(1'b0, 60);
    host.hold(1'b1, 8);
    chk_gain(1);
    chk("settled", 11'h000, 11'(settled));
    tick(SETTLE);
    chk("settled", 11'h001, 11'(settled));
    $display("t_enable done");
  endtask

  // walks the table through the wrap; one low sits one cycle under LO_MAX
  task automatic t_steps();
    for (int k = 2; k <= 7; k++) begin
      host.pulse((k == 4) ? LO_MAX - 1 : 50, 50);
      chk_gain(k % 6);
    end
    host.pulse(40, 50);
    chk_gain(1);
    $display("t_steps done");
  endtask

  task automatic t_long_low();
    host.hold(1'b0, LO_MAX + 10);
    chk_on(1'b0);
    host.wake();
    chk_on(1'b1);
    chk_gain(0);
    $display("t_long_low done");
  endtask

  task automatic t_lockout();
    lockout = 1'b1;
    tick(6);
    chk_on(1'b0);
    lockout = 1'b0;
    host.hold(1'b0, LO_MAX + 10);
    host.wake();
    chk_on(1'b1);
    $display("t_lockout done");
  endtask

  // a pulse during the hot state must not move the gain kept across it
  task automatic t_thermal();
    host.pulse(60, 60);
    hot = 1'b1;
    tick(6);
    chk_on(1'b0);
    host.pulse(60, 60);
    hot = 1'b0;
    cooled = 1'b1;
    tick(6);
    chk_on(1'b1);
    chk_gain(1);
    cooled = 1'b0;
    $display("t_thermal done");
  endtask

  task automatic t_pump();
    reg_ok = 3'b110;
    tick(STEP - 2);
    chk("pump_mode", 11'h001, 11'(pmode));
    for (int k = 1; k <= 3; k++) begin
      tick((k == 1) ? 5 : STEP + 1);
      chk("pump_mode", 11'h001 << k, 11'(pmode));
    end
    tick(STEP + 5);
    chk("pump_mode", 11'h008, 11'(pmode));
    enough = 1'b1;
    tick(2);
    chk("pump_mode", 11'h001, 11'(pmode));
    enough = 1'b0;
    tick(STEP + 4);
    chk("pump_mode", 11'h002, 11'(pmode));
    ovp = 1'b1;
    tick(2);
    chk("pump_mode", 11'h001, 11'(pmode));
    ovp = 1'b0;
    open = 3'b001;
    tick(3 * STEP);
    chk("pump_mode", 11'h001, 11'(pmode));
    reg_ok = 3'b000;
    open = 3'b000;
    tick(STEP + 4);
    chk("pump_mode", 11'h002, 11'(pmode));
    // from a raised mode, so the forced return is visible
    open = 3'b111;
    tick(2);
    chk("pump_mode", 11'h001, 11'(pmode));
    chk_on(1'b1);
    reg_ok = 3'b111;
    open = 3'b000;
    $display("t_pump done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    lockout = 1'b0;
    ovp = 1'b0;
    hot = 1'b0;
    cooled = 1'b0;
    enough = 1'b0;
    reg_ok = 3'b111;
    open = 3'b000;
    tick(3);
    srst = 1'b0;
    tick(1);
    t_reset();
    t_enable();
    t_steps();
    t_long_low();
    t_lockout();
    t_thermal();
    t_pump();
    summarize();
  end
endmodule

`default_nettype wire
